// [hdl/fcsc_cmd_exec.sv]
// Command executor: one active operation plus one buffered command behind a burst program.
`timescale 1ns/1ps
`include "fcsc_defs.svh"
module fcsc_cmd_exec
   import fcsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   fcsc_cmd_if.exec cif,
   output logic arrayStart,
   output logic [7:0] arrayCmd,
   output logic [15:0] arrayAddr,
   output logic [7:0] arrayData
);
   logic busy_q;
   logic [5:0] timer_q;
   logic pend_q;
   logic [7:0] pendCmd_q;
   logic [15:0] pendAddr_q;
   logic [7:0] pendData_q;
   logic finish;
   logic moveToArray;

   assign finish = busy_q && (timer_q == 6'h01);
   assign moveToArray = pend_q && (!busy_q || finish) && !cif.stopReq;

   // Pending slot: a launch parks here until the array is free.
   always_ff @(posedge clk) begin
      if (!rst_b || cif.stopReq) begin
         pend_q <= 1'b0;
      end else if (cif.launch) begin
         pend_q <= 1'b1;
         pendCmd_q <= cif.launchCmd;
         pendAddr_q <= cif.launchAddr;
         pendData_q <= cif.launchData;
      end else if (moveToArray) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         timer_q <= 6'h00;
         arrayStart <= 1'b0;
         arrayCmd <= 8'h00;
         arrayAddr <= 16'h0000;
         arrayData <= 8'h00;
      end else begin
         arrayStart <= moveToArray;
         if (cif.stopReq) begin
            busy_q <= 1'b0;
         end else if (moveToArray) begin
            busy_q <= 1'b1;
            timer_q <= `FCSC_EXEC_CYCLES;
            arrayCmd <= pendCmd_q;
            arrayAddr <= pendAddr_q;
            arrayData <= pendData_q;
         end else if (finish) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            timer_q <= timer_q - 6'h01;
         end
      end
   end

   // Only a burst program frees the buffer when it reaches an idle array; others hold it.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cif.bufEmpty <= 1'b1;
      end else if (cif.stopReq) begin
         cif.bufEmpty <= 1'b1;
      end else if (cif.launch) begin
         cif.bufEmpty <= 1'b0;
      end else if (finish) begin
         cif.bufEmpty <= !pend_q;
      end else if (moveToArray && pendCmd_q == `FCSC_CMD_BURSTPROG) begin
         cif.bufEmpty <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cif.complete <= 1'b1;
         cif.done <= 1'b0;
         cif.doneCmd <= 8'h00;
         cif.aborted <= 1'b0;
      end else begin
         // Complete trails finish by two cycles so that it rises with the blank flag.
         cif.complete <= !cif.launch && !pend_q && !moveToArray && !busy_q;
         cif.done <= finish && !cif.stopReq;
         cif.doneCmd <= arrayCmd;
         cif.aborted <= cif.stopReq && (busy_q || pend_q || cif.launch);
      end
   end
endmodule

// [hdl/fcsc_cmd_if.sv]
// Command hand-off between the register front end and the command executor.
`timescale 1ns/1ps
interface fcsc_cmd_if;
   logic launch;
   logic [7:0] launchCmd;
   logic [15:0] launchAddr;
   logic [7:0] launchData;
   logic stopReq;
   logic bufEmpty;
   logic complete;
   logic done;
   logic [7:0] doneCmd;
   logic aborted;
   modport front (output launch, launchCmd, launchAddr, launchData, stopReq,
      input bufEmpty, complete, done, doneCmd, aborted);
   modport exec (input launch, launchCmd, launchAddr, launchData, stopReq,
      output bufEmpty, complete, done, doneCmd, aborted);
endinterface

// [hdl/fcsc_defs.svh]
// Register offsets, field positions, reset values and timing counts of the flash front end.
`ifndef FCSC_DEFS_SVH
`define FCSC_DEFS_SVH

`define FCSC_OFS_DIVIDER 12'h000
`define FCSC_OFS_OPTION 12'h004
`define FCSC_OFS_CONFIG 12'h008
`define FCSC_OFS_PROTECT 12'h00c
`define FCSC_OFS_STATUS 12'h010
`define FCSC_OFS_COMMAND 12'h014
`define FCSC_ARRAY_SEL_BIT 18

`define FCSC_OPT_BACKDOOR_UNLOCK_ENABLE 7
`define FCSC_OPT_NORED 6
`define FCSC_CFG_KEY_WRITE_ACCESS 5
`define FCSC_ST_BUFEMPTY 7
`define FCSC_ST_COMPLETE 6
`define FCSC_ST_PVIOL 5
`define FCSC_ST_ACCERR 4
`define FCSC_ST_BLANK 2
`define FCSC_DIV_LOADED 7

`define FCSC_SEC_UNSECURE 2'h2
`define FCSC_KEY_BASE 16'hffb0
`define FCSC_KEY_LAST 16'hffb7
`define FCSC_KEY_BYTES 8
`define FCSC_CMD_BLANK 8'h05
`define FCSC_CMD_BYTEPROG 8'h20
`define FCSC_CMD_BURSTPROG 8'h25
`define FCSC_CMD_PAGEERASE 8'h40
`define FCSC_CMD_MASSERASE 8'h41
`define FCSC_PAGE_LSB 9
`define FCSC_EXEC_CYCLES 6'h10
`define FCSC_CFG_RESET 8'h00
`define FCSC_DIV_RESET 8'h00

`endif

// [hdl/fcsc_flash_front.sv]
// Register front end of the program-memory controller on an APB slave port.
`timescale 1ns/1ps
`include "fcsc_defs.svh"
// Overview of operation
// - Option copy loads from nonvolatile at reset; bits 5:2 read zero; writes ignored.
// - Key unlock disabled when option bit 7 clear; keys only from secured code.
// - Eight ascending key bytes matching stored key unlock until next reset.
// - Option bit 6 set disables vector redirection; clear enables it.
// - Security field unsecured only for 1:0; every other pattern means secure.
// - Security becomes 1:0 after good key entry or fully blank check.
// - Config bits 7:5 read/write; bits 4:0 read zero, ignore writes.
// - Key access set: key window writes are key bytes; else command start.
// - Protect copy loads from nonvolatile at reset; readable any time.
// - Protection only lowers select while disable is zero; else unchanged.
// - Select field sets unprotected end; protected locations refuse program/erase.
// - Protect bit 0 set protects nothing; clear protects the selected block.
// - Status bits 3,1,0 read zero; other five readable any time.
// - Writing one to bit 7 launches; burst program alone is buffered.
// - Complete flag set when buffer empty and idle; clears on launch.
// - Protected target sets violation flag and drops the command; write one clears.
// - Sequence error, no divider or stop during a command sets access error; one clears.
// - Blank flag sets after blank check of erased array; clears on launch.
// - Codes 05, 20, 25 are blank check, byte program and burst program.
// - Code 40 erases one 512-byte page; code 41 erases everything.
// - Any other code is illegal and raises the access error flag.
// - Divisor-loaded clears at reset, sets on first divider write; gates program/erase.
// - Clearing key access compares entered bytes; match makes security unsecured.
module fcsc_flash_front
   import fcsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] optionNonvolatileLoc,
   input wire logic [7:0] protectNonvolatileLoc,
   input wire logic [63:0] storedUnlockKey,
   input wire logic secureSource,
   input wire logic stopEntry,
   input wire logic arrayAllErased,
   output logic securityEngaged,
   output logic vectorRedirectEnable,
   output logic [6:0] clockDivisor,
   output logic arrayStart,
   output logic [7:0] arrayCmd,
   output logic [15:0] arrayAddr,
   output logic [7:0] arrayData
);
   fcsc_cmd_if cif ();

   logic [7:0] optionWorkingReg_q;
   logic [1:0] securityState_q;
   logic [7:0] configReg_q;
   logic [6:0] protectSelect_q;
   logic protectDisable_q;
   logic divisorLoaded_q;
   logic [6:0] divider_q;
   logic protectViolation_q;
   logic accessError_q;
   logic arrayBlank_q;
   fcsc_seq_e seq_q;
   fcsc_addr_t seqAddr_q;
   fcsc_byte_t seqData_q;
   fcsc_byte_t seqCmd_q;
   logic launch_q;
   logic unlock;
   logic [31:0] rdData;
   logic mapped;

   logic access;
   logic wrEn;
   logic arraySel;
   logic [11:0] regOfs;
   logic [15:0] location;
   logic keyAccess;
   logic inKeyWindow;
   logic keyWrite;
   logic arrayWrite;
   logic cmdWrite;
   logic launchWrite;
   logic launchOk;
   logic launchBad;
   logic launchProt;

   function automatic logic cmdKnown(input fcsc_byte_t c);
      cmdKnown = c == `FCSC_CMD_BLANK || c == `FCSC_CMD_BYTEPROG ||
         c == `FCSC_CMD_BURSTPROG || c == `FCSC_CMD_PAGEERASE ||
         c == `FCSC_CMD_MASSERASE;
   endfunction

   function automatic logic cmdAltersArray(input fcsc_byte_t c);
      cmdAltersArray = c != `FCSC_CMD_BLANK;
   endfunction

   // The unprotected region ends at the top of the page named by the select field.
   function automatic logic isProtected(input fcsc_byte_t c, input fcsc_addr_t a,
      input logic [6:0] sel, input logic dis);
      logic [15:0] lastFree;
      lastFree = {sel, 9'h1ff};
      if (dis || !cmdAltersArray(c)) begin
         isProtected = 1'b0;
      end else if (c == `FCSC_CMD_MASSERASE) begin
         isProtected = lastFree != 16'hffff;
      end else if (c == `FCSC_CMD_PAGEERASE) begin
         isProtected = {a[15:`FCSC_PAGE_LSB], 9'h000} > lastFree;
      end else begin
         isProtected = a > lastFree;
      end
   endfunction

   // A completed transfer is the access cycle in which pready is already high.
   assign access = psel && penable && pready;
   assign wrEn = access && pwrite;
   assign arraySel = paddr[31:`FCSC_ARRAY_SEL_BIT] == 14'h0001;
   assign regOfs = paddr[11:0];
   assign location = paddr[17:2];
   assign keyAccess = configReg_q[`FCSC_CFG_KEY_WRITE_ACCESS];
   assign inKeyWindow = location >= `FCSC_KEY_BASE && location <= `FCSC_KEY_LAST;
   assign keyWrite = wrEn && arraySel && keyAccess && inKeyWindow &&
      optionWorkingReg_q[`FCSC_OPT_BACKDOOR_UNLOCK_ENABLE] && secureSource;
   assign arrayWrite = wrEn && arraySel && !(keyAccess && inKeyWindow);
   assign cmdWrite = wrEn && !arraySel && regOfs == `FCSC_OFS_COMMAND;
   assign launchWrite = wrEn && !arraySel && regOfs == `FCSC_OFS_STATUS &&
      pwdata[`FCSC_ST_BUFEMPTY] && cif.bufEmpty;
   assign launchBad = launchWrite && (seq_q != SEQ_CMD || !cmdKnown(seqCmd_q) ||
      (cmdAltersArray(seqCmd_q) && !divisorLoaded_q));
   assign launchProt = launchWrite && !launchBad &&
      isProtected(seqCmd_q, seqAddr_q, protectSelect_q, protectDisable_q);
   assign launchOk = launchWrite && !launchBad && !launchProt;

   fcsc_key_check keyCheck (
      .clk(clk),
      .rst_b(rst_b),
      .storedKey(storedUnlockKey),
      .keyEnable(optionWorkingReg_q[`FCSC_OPT_BACKDOOR_UNLOCK_ENABLE]),
      .keyAccess(keyAccess),
      .keyWrite(keyWrite),
      .secureSource(secureSource),
      .keyIndex(location[2:0]),
      .keyByte(pwdata[7:0]),
      .unlock(unlock)
   );

   fcsc_cmd_exec cmdExec (
      .clk(clk),
      .rst_b(rst_b),
      .cif(cif),
      .arrayStart(arrayStart),
      .arrayCmd(arrayCmd),
      .arrayAddr(arrayAddr),
      .arrayData(arrayData)
   );

   assign cif.launch = launch_q;
   assign cif.launchCmd = seqCmd_q;
   assign cif.launchAddr = seqAddr_q;
   assign cif.launchData = seqData_q;
   assign cif.stopReq = stopEntry;

   // APB: one wait state so that read data and pready both leave flip-flops.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : rdData;
         pslverr <= !mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_comb begin
      rdData = 32'h00000000;
      mapped = 1'b1;
      if (arraySel) begin
         rdData = 32'h00000000;
      end else begin
         case (regOfs)
            `FCSC_OFS_DIVIDER: rdData[7:0] = {divisorLoaded_q, divider_q};
            `FCSC_OFS_OPTION: rdData[7:0] = {optionWorkingReg_q[7:6], 4'h0,
               securityState_q};
            `FCSC_OFS_CONFIG: rdData[7:0] = {configReg_q[7:5], 5'h00};
            `FCSC_OFS_PROTECT: rdData[7:0] = {protectSelect_q, protectDisable_q};
            `FCSC_OFS_STATUS: rdData[7:0] = {cif.bufEmpty, cif.complete,
               protectViolation_q, accessError_q, 1'b0, arrayBlank_q, 2'h0};
            `FCSC_OFS_COMMAND: rdData[7:0] = 8'h00;
            default: mapped = 1'b0;
         endcase
      end
   end

   // The option copy is taken during reset; software writes never reach it.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         optionWorkingReg_q <= optionNonvolatileLoc;
      end
   end

   // Working security field: left only by a key match or a fully blank check.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         securityState_q <= optionNonvolatileLoc[1:0];
      end else if (unlock || (cif.done && cif.doneCmd == `FCSC_CMD_BLANK && arrayAllErased)) begin
         securityState_q <= `FCSC_SEC_UNSECURE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         securityEngaged <= 1'b1;
         vectorRedirectEnable <= 1'b0;
      end else begin
         securityEngaged <= securityState_q != `FCSC_SEC_UNSECURE;
         vectorRedirectEnable <= !optionWorkingReg_q[`FCSC_OPT_NORED];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         configReg_q <= `FCSC_CFG_RESET;
      end else if (wrEn && !arraySel && regOfs == `FCSC_OFS_CONFIG) begin
         configReg_q <= {pwdata[7:5], 5'h00};
      end
   end

   // Protection may only grow: a lower select is taken while disable is clear, a higher one is dropped.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         protectSelect_q <= protectNonvolatileLoc[7:1];
         protectDisable_q <= protectNonvolatileLoc[0];
      end else if (wrEn && !arraySel && regOfs == `FCSC_OFS_PROTECT &&
         !protectDisable_q && pwdata[7:1] < protectSelect_q) begin
         protectSelect_q <= pwdata[7:1];
      end
   end

   // The divider is write-once; the first write of any value arms program and erase.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         divisorLoaded_q <= 1'b0;
         divider_q <= 7'h00;
      end else if (wrEn && !arraySel && regOfs == `FCSC_OFS_DIVIDER && !divisorLoaded_q) begin
         divisorLoaded_q <= 1'b1;
         divider_q <= pwdata[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clockDivisor <= 7'h00;
      end else begin
         clockDivisor <= divider_q;
      end
   end

   // Command sequence: array write, then command code, then launch.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         seq_q <= SEQ_IDLE;
         seqAddr_q <= 16'h0000;
         seqData_q <= 8'h00;
         seqCmd_q <= 8'h00;
      end else begin
         case (seq_q)
            SEQ_IDLE: begin
               if (arrayWrite && cif.bufEmpty) begin
                  seq_q <= SEQ_DATA;
                  seqAddr_q <= location;
                  seqData_q <= pwdata[7:0];
               end
            end
            SEQ_DATA: begin
               if (cmdWrite) begin
                  seq_q <= SEQ_CMD;
                  seqCmd_q <= pwdata[7:0];
               end else if (arrayWrite || launchWrite) begin
                  seq_q <= SEQ_IDLE;
               end
            end
            SEQ_CMD: begin
               if (launchWrite || arrayWrite || cmdWrite) begin
                  seq_q <= SEQ_IDLE;
               end
            end
            default: seq_q <= SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         launch_q <= 1'b0;
      end else begin
         launch_q <= launchOk;
      end
   end

   // A refused command never reaches the executor; the flag records why.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         protectViolation_q <= 1'b0;
      end else if (launchProt) begin
         protectViolation_q <= 1'b1;
      end else if (wrEn && !arraySel && regOfs == `FCSC_OFS_STATUS && pwdata[`FCSC_ST_PVIOL]) begin
         protectViolation_q <= 1'b0;
      end
   end

   // Out-of-order writes also count as sequence violations; set wins over clear.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         accessError_q <= 1'b0;
      end else if (launchBad || cif.aborted || (cmdWrite && seq_q != SEQ_DATA) ||
         (arrayWrite && seq_q != SEQ_IDLE)) begin
         accessError_q <= 1'b1;
      end else if (wrEn && !arraySel && regOfs == `FCSC_OFS_STATUS && pwdata[`FCSC_ST_ACCERR]) begin
         accessError_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         arrayBlank_q <= 1'b0;
      end else if (cif.done && cif.doneCmd == `FCSC_CMD_BLANK && arrayAllErased) begin
         arrayBlank_q <= 1'b1;
      end else if (launchOk) begin
         arrayBlank_q <= 1'b0;
      end
   end
endmodule

// [hdl/fcsc_key_check.sv]
// Backdoor key capture and comparison against the stored key.
`timescale 1ns/1ps
`include "fcsc_defs.svh"
module fcsc_key_check
   import fcsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [63:0] storedKey,
   input wire logic keyEnable,
   input wire logic keyAccess,
   input wire logic keyWrite,
   input wire logic secureSource,
   input wire logic [2:0] keyIndex,
   input wire logic [7:0] keyByte,
   output logic unlock
);
   logic [7:0] entered_q [`FCSC_KEY_BYTES];
   logic [3:0] count_q;
   logic orderOk_q;
   logic keyAccess_q;
   logic [`FCSC_KEY_BYTES-1:0] byteMatch;

   genvar g;
   generate
      for (g = 0; g < `FCSC_KEY_BYTES; g++) begin : gByte
         assign byteMatch[g] = entered_q[g] == storedKey[8*g +: 8];
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               entered_q[g] <= 8'h00;
            end else if (keyWrite && keyIndex == 3'(g)) begin
               entered_q[g] <= keyByte;
            end
         end
      end
   endgenerate

   // Bytes must arrive in ascending order, all from secured code.
   always_ff @(posedge clk) begin
      if (!rst_b || (keyAccess && !keyAccess_q)) begin
         count_q <= 4'h0;
         orderOk_q <= 1'b1;
      end else if (keyWrite) begin
         if (count_q < 4'h8) begin
            count_q <= count_q + 4'h1;
         end
         if (!secureSource || {1'b0, keyIndex} != count_q) begin
            orderOk_q <= 1'b0;
         end
      end
   end

   // The comparison runs on the falling edge of key access.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         keyAccess_q <= 1'b0;
         unlock <= 1'b0;
      end else begin
         keyAccess_q <= keyAccess;
         unlock <= keyAccess_q && !keyAccess && keyEnable && orderOk_q &&
            count_q == 4'h8 && &byteMatch;
      end
   end
endmodule

// [hdl/fcsc_pkg.sv]
// Types shared by the flash front end modules.
package fcsc_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h0,
      SEQ_DATA = 2'h1,
      SEQ_CMD = 2'h3
   } fcsc_seq_e;
   typedef logic [7:0] fcsc_byte_t;
   typedef logic [15:0] fcsc_addr_t;
endpackage

// [test/fcsc_flash_front_test.sv]
// Self-checking bench for the flash register front end.
`timescale 1ns/1ps
`include "fcsc_defs.svh"
module fcsc_flash_front_test
   import fcsc_pkg::*;
   ;
   typedef struct {logic [31:0] a; logic [7:0] w; logic [7:0] e; logic er;} fcsc_row_s;
   localparam logic [31:0] ofsDivider = {20'h0, `FCSC_OFS_DIVIDER};
   localparam logic [31:0] ofsOption = {20'h0, `FCSC_OFS_OPTION};
   localparam logic [31:0] ofsConfig = {20'h0, `FCSC_OFS_CONFIG};
   localparam logic [31:0] ofsProtect = {20'h0, `FCSC_OFS_PROTECT};
   localparam logic [31:0] ofsStatus = {20'h0, `FCSC_OFS_STATUS};
   localparam logic [31:0] ofsCommand = {20'h0, `FCSC_OFS_COMMAND};
   logic clk;
   logic rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, secEng, redirEn, aStart;
   logic [7:0] optNv = 8'hbd, protNv = 8'hff, aCmd, aData, seenCmd, seenData;
   logic [63:0] key = 64'h0123456789abcdef;
   logic secSrc = 1'b0, stopIn = 1'b0, allErased = 1'b1;
   logic [6:0] clkDiv;
   logic [15:0] aAddr, seenAddr;
   int failures = 0, check_count = 0, startCount = 0;
   logic [7:0] codes [5] = '{`FCSC_CMD_BYTEPROG, `FCSC_CMD_BLANK, `FCSC_CMD_BURSTPROG,
      `FCSC_CMD_PAGEERASE, `FCSC_CMD_MASSERASE};
   fcsc_row_s rows [7] = '{'{ofsConfig, 8'hff, 8'he0, 1'b0}, '{ofsConfig, 8'h00, 8'h00, 1'b0},
      '{ofsOption, 8'hff, 8'h81, 1'b0}, '{ofsProtect, 8'h00, 8'hff, 1'b0},
      '{ofsCommand, 8'h25, 8'h00, 1'b0}, '{ofsStatus, 8'h1e, 8'hc0, 1'b0},
      '{32'h18, 8'h5a, 8'h00, 1'b1}};
   fcsc_flash_front i_fcsc_flash_front (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .optionNonvolatileLoc(optNv),
      .protectNonvolatileLoc(protNv), .storedUnlockKey(key), .secureSource(secSrc),
      .stopEntry(stopIn), .arrayAllErased(allErased), .securityEngaged(secEng),
      .vectorRedirectEnable(redirEn), .clockDivisor(clkDiv), .arrayStart(aStart),
      .arrayCmd(aCmd), .arrayAddr(aAddr), .arrayData(aData));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Start pulses last one cycle; a monitor catches each one.
   always @(posedge clk) begin
      if (aStart === 1'b1) begin
         seenCmd <= aCmd;
         seenAddr <= aAddr;
         seenData <= aData;
         startCount <= startCount + 1;
      end
   end
   function automatic logic [31:0] loc(input logic [15:0] l);
      return 32'h40000 + {14'h0, l, 2'h0};
   endfunction
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Polls status until complete, which an accepted launch drops before the first poll.
   task automatic runCmd(input logic [7:0] code, input logic [15:0] l, input logic stop = 1'b0);
      apb(1'b1, loc(l), 32'h5a);
      apb(1'b1, ofsCommand, {24'h0, code});
      apb(1'b1, ofsStatus, 32'h80);
      stopIn <= stop;
      @(posedge clk);
      stopIn <= 1'b0;
      do begin
         apb(1'b0, ofsStatus, 32'h0);
      end while (rd[6] !== 1'b1);
   endtask
   task automatic keyEntry(input logic [63:0] k);
      apb(1'b1, ofsConfig, 32'h20);
      secSrc <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, loc(16'hffb0 + 16'(i)), {24'h0, k[8*i +: 8]});
      end
      secSrc <= 1'b0;
      apb(1'b1, ofsConfig, 32'h0);
      repeat (4) @(posedge clk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      failures++;
      summarize;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      chk("security", 8'h1, {7'h0, secEng});
      chk("redirect", 8'h1, {7'h0, redirEn});
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, {24'h0, rows[i].w});
         apb(1'b0, rows[i].a, 32'h0);
         chk("register", rows[i].e, rd[7:0]);
         chk("slave error", {7'h0, rows[i].er}, {7'h0, err});
      end
      $display("test register table done");
      runCmd(`FCSC_CMD_BYTEPROG, 16'h1000);
      chk("status", 8'hd0, rd[7:0]);
      apb(1'b1, ofsStatus, 32'h10);
      apb(1'b1, ofsDivider, 32'h05);
      apb(1'b1, ofsDivider, 32'h07);
      apb(1'b0, ofsDivider, 32'h0);
      chk("divider", 8'h85, rd[7:0]);
      runCmd(8'h33, 16'h1000);
      chk("status", 8'hd0, rd[7:0]);
      apb(1'b1, ofsStatus, 32'h10);
      chk("starts", 8'h0, 8'(startCount));
      for (int i = 0; i < 5; i++) begin
         runCmd(codes[i], 16'h1000 + 16'(i));
         chk("command", codes[i], seenCmd);
         chk("address", 8'(i), seenAddr[7:0]);
         chk("data", 8'h5a, seenData);
         chk("status", (codes[i] == 8'h05) ? 8'hc4 : 8'hc0, rd[7:0]);
      end
      chk("security", 8'h0, {7'h0, secEng});
      $display("test commands done");
      protNv <= 8'hfc;
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      chk("security", 8'h1, {7'h0, secEng});
      apb(1'b1, ofsDivider, 32'h05);
      apb(1'b1, ofsProtect, 32'hf0);
      apb(1'b0, ofsProtect, 32'h0);
      chk("protect", 8'hf0, rd[7:0]);
      apb(1'b1, ofsProtect, 32'hfe);
      apb(1'b0, ofsProtect, 32'h0);
      chk("protect", 8'hf0, rd[7:0]);
      runCmd(`FCSC_CMD_BYTEPROG, 16'hff00);
      chk("status", 8'he0, rd[7:0]);
      apb(1'b1, ofsStatus, 32'h20);
      runCmd(`FCSC_CMD_BYTEPROG, 16'hf100);
      chk("status", 8'hc0, rd[7:0]);
      runCmd(`FCSC_CMD_BYTEPROG, 16'hf100, 1'b1);
      chk("status", 8'hd0, rd[7:0]);
      chk("starts", 8'h6, 8'(startCount));
      $display("test protection done");
      keyEntry(~key);
      chk("security", 8'h1, {7'h0, secEng});
      keyEntry(key);
      chk("security", 8'h0, {7'h0, secEng});
      chk("starts", 8'h6, 8'(startCount));
      $display("test key entry done");
      summarize;
   end
endmodule

// [test/fcsc_front_checker.sv]
// Concurrent checks on the register and command ports of the flash front end.
`timescale 1ns/1ps
module fcsc_front_checker
   import fcsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic securityEngaged,
   input wire logic vectorRedirectEnable,
   input wire logic [6:0] clockDivisor,
   input wire logic arrayStart,
   input wire logic [7:0] arrayCmd
);
   logic rdDone;
   // Full address compare: array window offsets alias the registers.
   assign rdDone = psel && penable && pready && !pwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_option_rsvd_zero: assert property (rdDone && paddr == 32'h4 |-> prdata[5:2] == 4'h0)
      else $error("option reserved bits not zero");
   a_config_low_zero: assert property (rdDone && paddr == 32'h8 |-> prdata[4:0] == 5'h0)
      else $error("config low bits not zero");
   a_status_rsvd_zero: assert property (rdDone && paddr == 32'h10 |->
      {prdata[3], prdata[1:0]} == 3'h0) else $error("status reserved bits not zero");
   a_command_reads_zero: assert property (rdDone && paddr == 32'h14 |-> prdata == 32'h0)
      else $error("command register read not zero");
   a_read_high_zero: assert property (rdDone |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_redirect_follows: assert property (rdDone && paddr == 32'h4 |->
      prdata[6] != vectorRedirectEnable) else $error("redirect enable disagrees with option bit");
   a_secure_code: assert property (rdDone && paddr == 32'h4 |->
      securityEngaged == (prdata[1:0] != 2'h2))
      else $error("security output disagrees with security field");
   a_divider_copy: assert property (rdDone && paddr == 32'h0 |->
      prdata[6:0] == clockDivisor) else $error("divider output disagrees with register");
   a_known_code: assert property (arrayStart |->
      arrayCmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
      else $error("array started with an illegal command");
   a_start_pulse: assert property (arrayStart |=> !arrayStart)
      else $error("array start longer than one cycle");
   a_ready_pulse: assert property (pready |=> !pready ##1 !pready)
      else $error("ready not a single pulse");
   c_blank_start: cover property (arrayStart && arrayCmd == 8'h05);
   c_slave_error: cover property (pslverr && pready);
   c_unlocked: cover property ($fell(securityEngaged));
endmodule
bind fcsc_flash_front fcsc_front_checker i_fcsc_front_checker (.clk(clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .securityEngaged(securityEngaged),
   .vectorRedirectEnable(vectorRedirectEnable), .clockDivisor(clockDivisor),
   .arrayStart(arrayStart), .arrayCmd(arrayCmd));
